/* hw/ita_pkg.sv */
// Purpose: constants and types for the indirect table access port
// Assumes: classic Wishbone, 32-bit data, 16-bit registers in low lanes
// Notes: a register index n sits at byte address 4*n
package ita_pkg;
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned REG_W  = 16;
    localparam int unsigned WORD_W = 67;
    localparam int unsigned IDX_W  = 10;
    localparam int unsigned TADR_W = 12;
    localparam int unsigned CNT_W  = 4;

    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_CMD  = 6'h00;
    localparam logic [5:0] IDX_DAT1 = 6'h02;
    localparam logic [5:0] IDX_DAT2 = 6'h04;
    localparam logic [5:0] IDX_DAT3 = 6'h06;
    localparam logic [5:0] IDX_DAT4 = 6'h08;
    localparam logic [5:0] IDX_DAT5 = 6'h0a;

    // Command register fields
    localparam int unsigned CMD_DIR_BIT = 12;
    localparam int unsigned CMD_TBL_MSB = 11;
    localparam int unsigned CMD_TBL_LSB = 10;
    localparam int unsigned CMD_IDX_MSB = 9;

    // Status and data slices
    localparam int unsigned PEND_BIT = 7;
    localparam int unsigned D1_LSB   = 64;
    localparam int unsigned D1_W     = 3;
    localparam int unsigned D2_LSB   = 32;
    localparam int unsigned D3_LSB   = 48;
    localparam int unsigned D4_LSB   = 0;
    localparam int unsigned D5_LSB   = 16;

    // Values after reset
    localparam logic [REG_W-1:0]  CMD_RST  = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 67'h0;

    // Slow table read time, rounded up to whole cycles
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SLOW_READ_NS  = 40;
    localparam int unsigned SLOW_READ_CYC =
        (SLOW_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TBL_STATIC  = 2'h0,
        TBL_VLAN    = 2'h1,
        TBL_DYNAMIC = 2'h2,
        TBL_MIB     = 2'h3
    } ita_tbl_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WRITE = 5'h02,
        ST_READ  = 5'h04,
        ST_WAIT  = 5'h08,
        ST_LOAD  = 5'h10
    } ita_state_t;
endpackage

/* hw/ita_tbl_if.sv */
// Purpose: link between the command engine and the table storage
// Assumes: one clock, read data registered inside the storage
// Notes: address is table code above entry index
interface ita_tbl_if;
    import ita_pkg::*;
    logic [TADR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] rdata;
    logic              we;
    logic              re;
    modport ctl (output addr, output wdata, output we, output re,
                 input rdata);
    modport mem (input addr, input wdata, input we, input re,
                 output rdata);
endinterface

/* hw/ita_table_mem.sv */
// Purpose: storage for all four tables, one 67-bit entry per address
// Assumes: single port, one access per cycle
// Notes: read data held in a register until the next read
module ita_table_mem
    import ita_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    ita_tbl_if.mem    bus
);
    logic [WORD_W-1:0] store [0:(1 << TADR_W) - 1];

    // Entry write; storage itself has no reset
    always_ff @(posedge clk) begin
        if (bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
    end

    // Registered read port, holds between reads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus.rdata <= WORD_RST;
        end else if (bus.re) begin
            bus.rdata <= store[bus.addr];
        end
    end
endmodule

/* hw/ita_top.sv */
// Purpose: indirect access port to the switch tables over Wishbone
// Assumes: classic single-cycle Wishbone master, 200 MHz clock
// Notes: command writes stall while a command is still running
//
// Decided for this implementation: the Wishbone interface to the registers.
module ita_top
    import ita_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [ita_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [ita_pkg::DAT_W-1:0] WB_DAT_I,
    output logic      [ita_pkg::DAT_W-1:0] WB_DAT_O,
    output logic                        WB_ACK_O,
    output logic                        CMD_BUSY
);
    import ita_pkg::*;

    logic [REG_W-1:0]  cmd;
    logic [WORD_W-1:0] word;
    logic              pending;
    ita_state_t        state;
    ita_state_t        next_state;
    logic [CNT_W-1:0]  wait_cnt;
    logic [5:0]        widx;
    logic              req;
    logic              stall;
    logic              wr_stb;
    logic              cmd_wr;
    logic [REG_W-1:0]  next_cmd;
    logic [REG_W-1:0]  rd_mux;
    logic              slow_tbl;
    logic              next_slow;
    logic              next_rd;

    ita_tbl_if tbl ();

    // Table storage behind the command engine
    ita_table_mem u_mem (
        .clk   (CLK),
        .rst_n (RST_N),
        .bus   (tbl)
    );

    // Byte-lane merge of a 16-bit register write
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0] old_v,
        input logic [REG_W-1:0] new_v,
        input logic [1:0]       sel
    );
        logic [REG_W-1:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // Bus decode; low address bits ignored, words are aligned
    assign widx   = WB_ADR_I[ADR_W-1:2];
    assign req    = WB_CYC_I & WB_STB_I;
    assign wr_stb = req & WB_WE_I & WB_ACK_O;
    assign cmd_wr = wr_stb & (widx == IDX_CMD);

    // A new command must wait until the engine is idle again
    assign stall  = req & WB_WE_I & (widx == IDX_CMD)
                  & (state != ST_IDLE);

    // Value that a command write leaves in the register
    assign next_cmd = merge16(cmd, WB_DAT_I[REG_W-1:0], WB_SEL_I[1:0]);

    assign next_rd = next_cmd[CMD_DIR_BIT];

    assign next_slow = (next_cmd[CMD_TBL_MSB:CMD_TBL_LSB] == TBL_DYNAMIC)
                    | (next_cmd[CMD_TBL_MSB:CMD_TBL_LSB] == TBL_MIB);
    assign slow_tbl  = (cmd[CMD_TBL_MSB:CMD_TBL_LSB] == TBL_DYNAMIC)
                    | (cmd[CMD_TBL_MSB:CMD_TBL_LSB] == TBL_MIB);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= req & ~WB_ACK_O & ~stall;
        end
    end

    // Read data registered together with the ack
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WB_DAT_O <= 32'h0;
        end else if (req & ~WB_ACK_O & ~stall & ~WB_WE_I) begin
            WB_DAT_O <= {16'h0, rd_mux};
        end else begin
            WB_DAT_O <= 32'h0;
        end
    end

    // Readback mux; unmapped words read as zero
    always_comb begin
        rd_mux = 16'h0000;
        case (widx)
            IDX_CMD: begin
                rd_mux = cmd;
            end
            IDX_DAT1: begin
                rd_mux[PEND_BIT] = pending;
                rd_mux[D1_W-1:0] = word[D1_LSB +: D1_W];
            end
            IDX_DAT2: begin
                rd_mux = word[D2_LSB +: REG_W];
            end
            IDX_DAT3: begin
                rd_mux = word[D3_LSB +: REG_W];
            end
            IDX_DAT4: begin
                rd_mux = word[D4_LSB +: REG_W];
            end
            IDX_DAT5: begin
                rd_mux = word[D5_LSB +: REG_W];
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // Command register; reserved bits 15-13 kept as written
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cmd <= CMD_RST;
        end else if (cmd_wr) begin
            cmd <= next_cmd;
        end
    end

    // Command engine sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_wr) begin
                    next_state = next_rd ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE: begin
                next_state = ST_IDLE;
            end
            ST_READ: begin
                next_state = slow_tbl ? ST_WAIT : ST_LOAD;
            end
            ST_WAIT: begin
                if (wait_cnt == '0) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Slow-table delay; counted from the storage read
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wait_cnt <= '0;
        end else if (state == ST_READ) begin
            wait_cnt <= CNT_W'(SLOW_READ_CYC - 1);
        end else if ((state == ST_WAIT) && (wait_cnt != '0)) begin
            wait_cnt <= wait_cnt - 1'b1;
        end
    end

    // Storage access driven from the held command
    // table code forms the upper address bits, entry index the lower
    assign tbl.addr  = {cmd[CMD_TBL_MSB:CMD_TBL_LSB],
                        cmd[CMD_IDX_MSB:0]};
    assign tbl.wdata = word;
    assign tbl.we    = (state == ST_WRITE);
    assign tbl.re    = (state == ST_READ);

    // Pending flag; start and finish never share a cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pending <= 1'b0;
        end else if (cmd_wr && (state == ST_IDLE)) begin
            pending <= next_rd & next_slow;
        end else if (state == ST_LOAD) begin
            pending <= 1'b0;
        end
    end

    // Data word: loaded by a read, else written by the host.
    // A load beats a host write in the same cycle, so the
    // result of a read is never half overwritten.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            word <= WORD_RST;
        end else if (state == ST_LOAD) begin
            word <= tbl.rdata;
        end else if (wr_stb) begin
            case (widx)
                IDX_DAT2: begin
                    word[D2_LSB +: REG_W] <= merge16(
                        word[D2_LSB +: REG_W],
                        WB_DAT_I[REG_W-1:0], WB_SEL_I[1:0]);
                end
                IDX_DAT3: begin
                    word[D3_LSB +: REG_W] <= merge16(
                        word[D3_LSB +: REG_W],
                        WB_DAT_I[REG_W-1:0], WB_SEL_I[1:0]);
                end
                IDX_DAT4: begin
                    word[D4_LSB +: REG_W] <= merge16(
                        word[D4_LSB +: REG_W],
                        WB_DAT_I[REG_W-1:0], WB_SEL_I[1:0]);
                end
                IDX_DAT5: begin
                    word[D5_LSB +: REG_W] <= merge16(
                        word[D5_LSB +: REG_W],
                        WB_DAT_I[REG_W-1:0], WB_SEL_I[1:0]);
                end
                default: begin
                    word <= word;
                end
            endcase
        end
    end

    // Busy level for system logic, from a flop
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CMD_BUSY <= 1'b0;
        end else begin
            CMD_BUSY <= (next_state != ST_IDLE);
        end
    end
endmodule

/* dv/ita_properties.sv */
// Purpose: port-level checks for the table access port
// Assumes: sees only the top ports, one clock domain
// Notes: bound into every ita_top instance at the foot
module ita_properties (
    input wire logic                      CLK,
    input wire logic                      RST_N,
    input wire logic                      WB_CYC_I,
    input wire logic                      WB_STB_I,
    input wire logic                      WB_WE_I,
    input wire logic [ita_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0]                WB_SEL_I,
    input wire logic [ita_pkg::DAT_W-1:0] WB_DAT_I,
    input wire logic [ita_pkg::DAT_W-1:0] WB_DAT_O,
    input wire logic                      WB_ACK_O,
    input wire logic                      CMD_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    import ita_pkg::*;
    logic       req;
    logic       cmd_go;
    logic [5:0] ridx;
    // A command starts on the ack edge of its register write
    assign ridx   = WB_ADR_I[7:2];
    assign req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign cmd_go = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O
                    & (ridx == IDX_CMD);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_write_one_cycle: assert property (
        cmd_go && !WB_DAT_I[12] |=> CMD_BUSY ##1 !CMD_BUSY)
        else $error("table write busy length wrong");
    a_fast_read_len: assert property (
        cmd_go && WB_DAT_I[12] && !WB_DAT_I[11]
        |=> CMD_BUSY[*2] ##1 !CMD_BUSY)
        else $error("fast read busy length wrong");
    a_slow_read_len: assert property (
        cmd_go && WB_DAT_I[12] && WB_DAT_I[11]
        |=> CMD_BUSY[*8] ##1 CMD_BUSY[*2] ##1 !CMD_BUSY)
        else $error("slow read busy length wrong");
    a_pend_while_busy: assert property (
        WB_ACK_O && !WB_WE_I && ridx == IDX_DAT1 && WB_DAT_O[7]
        |-> $past(CMD_BUSY))
        else $error("pending shown with engine idle");
    a_no_stray_cmd: assert property (
        !CMD_BUSY && !cmd_go |=> !CMD_BUSY)
        else $error("engine started without command");
    a_cmd_not_lost: assert property (
        req && WB_WE_I && ridx == IDX_CMD |-> ##[1:13] WB_ACK_O)
        else $error("command write never acked");
    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_data_ack_next: assert property (
        req && !(WB_WE_I && ridx == IDX_CMD) |=> WB_ACK_O)
        else $error("register access not acked next cycle");
    a_dat1_reserved: assert property (
        WB_ACK_O && !WB_WE_I && ridx == IDX_DAT1
        |-> WB_DAT_O[15:8] == 8'h00 && WB_DAT_O[6:3] == 4'h0)
        else $error("reserved status bits not zero");
    a_dat_out_clean: assert property (
        WB_DAT_O[31:16] == 16'h0000 && (WB_ACK_O || WB_DAT_O == 32'h0))
        else $error("read data outside ack or upper half");

    c_fast_read: cover property (cmd_go && WB_DAT_I[12] && !WB_DAT_I[11]);
    c_slow_read: cover property (cmd_go && WB_DAT_I[12] && WB_DAT_I[11]);
    c_tbl_write: cover property (cmd_go && !WB_DAT_I[12]);
    c_cmd_stall: cover property (req && WB_WE_I && ridx == IDX_CMD
                                 && CMD_BUSY);
endmodule

bind ita_top ita_properties i_ita_properties (
    .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .CMD_BUSY(CMD_BUSY));

/* dv/ita_host_model.sv */
// Purpose: host processor model on the Wishbone port
// Assumes: classic cycles, ack sampled on rising edges
// Notes: released lines carry inverted values, never stale ones
module ita_host_model (
    input  wire logic                      clk,
    output logic                           cyc,
    output logic                           stb,
    output logic                           we,
    output logic [ita_pkg::ADR_W-1:0]      adr,
    output logic [3:0]                     sel,
    output logic [ita_pkg::DAT_W-1:0]      dat_w,
    input  wire logic [ita_pkg::DAT_W-1:0] dat_r,
    input  wire logic                      ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import ita_pkg::*;
    logic [15:0] junk;
    // Bus idle from time zero
    initial begin
        {cyc, stb, we, adr, sel, dat_w} = '0;
    end

    // One cycle, held until ack; a random gap makes the host slow
    task automatic bus(input logic w, input logic [5:0] ri,
                       input logic [15:0] wd, output logic [15:0] rd);
        repeat ($urandom_range(1, 0)) @(posedge clk);
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {ri, 2'b00};
        sel <= 4'h3;
        dat_w <= {16'h0000, wd};
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_r[15:0];
        {cyc, stb} <= 2'b00;
        we <= ~w;
        sel <= 4'hc;
        adr <= ~{ri, 2'b00};
        dat_w <= ~{16'h0000, wd};
    endtask

    task automatic tbl_write(input logic [15:0] cmd, input logic [66:0] w);
        bus(1'b1, IDX_DAT2, w[47:32], junk);
        bus(1'b1, IDX_DAT3, w[63:48], junk);
        bus(1'b1, IDX_DAT4, w[15:0], junk);
        bus(1'b1, IDX_DAT5, w[31:16], junk);
        bus(1'b1, IDX_CMD, cmd, junk);
    endtask

    task automatic tbl_read(input logic [15:0] cmd, output logic pend,
                            output logic [66:0] w);
        logic [15:0] r;
        bus(1'b1, IDX_CMD, cmd, r);
        bus(1'b0, IDX_DAT1, 16'h0000, r);
        pend = r[PEND_BIT];
        while (r[PEND_BIT] !== 1'b0) bus(1'b0, IDX_DAT1, 16'h0000, r);
        bus(1'b0, IDX_DAT2, 16'h0000, w[47:32]);
        bus(1'b0, IDX_DAT3, 16'h0000, w[63:48]);
        bus(1'b0, IDX_DAT4, 16'h0000, w[15:0]);
        bus(1'b0, IDX_DAT5, 16'h0000, w[31:16]);
        bus(1'b0, IDX_DAT1, 16'h0000, r);
        w[66:64] = r[2:0];
    endtask
endmodule

/* dv/ita_top_tb.sv */
// Purpose: self-checking bench for the table access port
// Assumes: host model drives the bus, checker is bound in
// Notes: storage is not reset, so only written entries are read
module ita_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ita_pkg::*;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             cyc, stb, we, ack, busy, pend;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat_w, dat_r;
    logic [66:0]      word [8];
    logic [15:0]      cmd [8];
    logic [66:0]      got;
    logic [15:0]      r, d;
    int               err_total = 0;
    int               tests_run = 0;
    int               cycles = 0;

    ita_top i_ita_top (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .CMD_BUSY(busy));
    ita_host_model i_ita_host_model (.clk(clk), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r),
        .ack(ack));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic chk(input logic [66:0] seen, input logic [66:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard; the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        void'($urandom(80605));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then one unmapped index
        for (int i = 0; i < 7; i++) begin
            i_ita_host_model.bus(1'b0, 6'(2 * i), 16'h0000, r);
            chk(r, 67'h0);
        end
        // Data registers read back; word one ignores writes
        for (int k = 2; k <= 10; k += 2) begin
            d = 16'($urandom);
            i_ita_host_model.bus(1'b1, 6'(k), d, r);
            i_ita_host_model.bus(1'b0, 6'(k), 16'h0000, r);
            chk(r, (k == 2) ? 67'h0 : {51'h0, d});
        end
        // Every table, corner and random indexes
        for (int i = 0; i < 8; i++) begin
            cmd[i] = {4'h0, 2'(i % 4), (i < 4) ? {10{i[0]}}
                      : 10'($urandom_range(1022, 1))};
            word[i] = {3'b000, 32'($urandom), 32'($urandom)};
            i_ita_host_model.tbl_write(cmd[i], word[i]);
        end
        for (int i = 0; i < 8; i++) begin
            i_ita_host_model.tbl_read(cmd[i] | 16'h1000, pend, got);
            chk(got, word[i]);
            chk(pend, cmd[i][11]);
            i_ita_host_model.bus(1'b0, IDX_CMD, 16'h0000, r);
            chk(r, cmd[i] | 16'h1000);
        end
        // Command written during a slow read is held, then run once
        i_ita_host_model.bus(1'b1, IDX_CMD, cmd[2] | 16'h1000, r);
        i_ita_host_model.tbl_read(cmd[4] | 16'h1000, pend, got);
        chk(got, word[4]);
        final_report();
    end
endmodule
